// >>> serial_cfg_pkg.sv
// register map, field layout and types of the serial port configuration block
`default_nettype none

package serial_cfg_pkg;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam int          IDX_W       = 3;
  localparam int          ADR_LSB     = 2;
  localparam logic [2:0]  IDX_BAUD_HI = 3'h0;
  localparam logic [2:0]  IDX_BAUD_LO = 3'h1;
  localparam logic [2:0]  IDX_CTRL1   = 3'h2;
  localparam logic [2:0]  IDX_ALT_ST  = 3'h0;
  localparam logic [2:0]  IDX_ALT_C1  = 3'h1;
  localparam logic [2:0]  IDX_ALT_C2  = 3'h2;
  localparam logic [2:0]  IDX_CTRL2   = 3'h3;
  localparam logic [2:0]  IDX_STAT1   = 3'h4;
  localparam logic [2:0]  IDX_STAT2   = 3'h5;
  localparam logic [2:0]  IDX_DATA_HI = 3'h6;
  localparam logic [2:0]  IDX_DATA_LO = 3'h7;

  // ---------------------------------------------------------------
  // reset values and implemented-bit masks
  // ---------------------------------------------------------------
  localparam logic [15:0] BAUD_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  ALT_ST_W1C  = 8'h83;
  localparam logic [7:0]  ALT_C1_MASK = 8'h83;
  localparam logic [7:0]  ALT_C2_MASK = 8'he7;
  localparam logic [7:0]  STAT2_MASK  = 8'h1e;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int C1_LOOP  = 7;
  localparam int C1_WAIT  = 6;
  localparam int C1_RX_SOURCE_SELECT  = 5;
  localparam int C1_NINE  = 4;
  localparam int C1_WAKE  = 3;
  localparam int C1_ILT   = 2;
  localparam int C1_PAR   = 1;
  localparam int C1_ODD   = 0;
  localparam int C2_TXEN  = 3;
  localparam int C2_RXEN  = 2;
  localparam int S2_BANK  = 7;
  localparam int S2_TXDIR = 1;
  localparam int A2_IR    = 7;
  localparam int AS_BERRV = 2;
  localparam int S1_PERR  = 0;
  localparam int DH_RX8   = 7;
  localparam int DH_TX8   = 6;

  // last sample tick index of a bit time, sixteen ticks per bit
  localparam logic [3:0]  PHASE_LAST  = 4'hf;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic nine_bit;
    logic wake_addr;
    logic idle_after_stop;
    logic parity_on;
    logic parity_odd;
  } line_format_t;

  typedef struct packed {
    logic tx_pol;
    logic rx_pol;
    logic brk13;
    logic tx_dir;
  } pin_ctrl_t;

  typedef enum logic [1:0] {GEN_OFF, GEN_HOLD, GEN_RUN} gen_state_t;

endpackage

`default_nettype wire

// >>> serial_node.sv
// far serial node model driving the receive pin and the shared transmit line
`default_nettype none
module serial_node (
  // pin side of the block
  input  wire logic drv_i,
  input  wire logic drv_oe_n_i,
  // level the far node puts on its line
  input  wire logic far_level_i,
  // resolved lines
  output logic      rxd_o,
  output logic      txd_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // the block wins the shared wire only while its enable is low
  assign txd_line_o = drv_oe_n_i ? far_level_i : drv_i;
  assign rxd_o      = far_level_i;
endmodule
`default_nettype wire

// >>> serial_port_config_map.sv
// register map, baud generator and line routing of the serial port
`default_nettype none

// Notes on behaviour
// - reserved locations and bits ignore writes and read as zero.
// - bank 0 maps offsets 0..2 to divisor high, divisor low, control one.
// - bank 1 maps offsets 0..2 to alternate status, control one, two.
// - bank select resets to 0, divisor bank visible after reset.
// - infrared off: baud rate is bus clock over full divisor.
// - infrared on: baud rate is bus clock over twice divisor bits 15..1.
// - baud generator stays stopped until first transmit or receive enable.
// - generator off when divisor bits 15..4 (or 15..5 infrared) are zero.
// - loop disconnects receive pin, receiver fed by transmitter; needs both.
// - loop source 0 internal route, source 1 receiver reads transmit pin.
// - halt-in-wait set stops the port while system is in wait mode.
// - format bit selects eight or nine data bits, one start, one stop.
// - wake bit selects idle-line or address-mark (msb one) wakeup.
// - idle-count start bit counts ones after start or after stop bit.
// - eight registers decoded at base plus offsets 0 through 7.
// - parity on generates and checks a parity bit in msb position.
// - parity type 0 even, 1 odd; even count of ones clears bit.
// - transmit pin idles high, released whenever transmitter disabled.

module serial_port_config_map
  import serial_cfg_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [ADDR_W-1:0]        adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  // system
  input  wire logic                     wait_mode_i,
  // pins
  input  wire logic                     rxd_i,
  input  wire logic                     txd_i,
  output logic                          txd_o,
  output logic                          txd_oe_n_o,
  // datapath side
  input  wire logic                     tx_serial_i,
  input  wire logic [7:0]               line_status_i,
  input  wire logic                     raf_i,
  input  wire logic [2:0]               alt_event_i,
  input  wire logic                     berrv_i,
  input  wire logic [8:0]               rx_char_i,
  input  wire logic                     rx_char_valid_i,
  output logic                          rx_line_o,
  output logic                          tx_run_o,
  output logic                          rx_run_o,
  output logic                          rx_sample_tick_o,
  output logic                          baud_tick_o,
  output logic                          infrared_on_o,
  output serial_cfg_pkg::line_format_t  format_o,
  output serial_cfg_pkg::pin_ctrl_t     pin_ctrl_o,
  output logic      [7:0]               ctrl2_o,
  output logic      [7:0]               alt_enables_o,
  output logic      [7:0]               alt_modes_o,
  output logic      [8:0]               tx_char_o,
  output logic                          tx_load_o,
  output logic                          data_read_o,
  output logic                          address_mark_o
);
  import serial_cfg_pkg::*;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // sample period in bus clocks, sixteen samples per bit; infrared bit
  // time is twice bits 15..1, which over sixteen is again bits 15..4
  function automatic logic [11:0] sample_period(input logic [15:0] d,
                                                input logic ir);
    sample_period = ir ? {d[15:5], d[4]} : d[15:4];
  endfunction

  function automatic logic div_ok(input logic [15:0] d, input logic ir);
    div_ok = ir ? (|d[15:5]) : (|d[15:4]);
  endfunction

  // parity over the data bits below the msb position
  function automatic logic parity_of(input logic [8:0] c,
                                     input logic nine, input logic odd);
    parity_of = (nine ? (^c[7:0]) : (^c[6:0])) ^ odd;
  endfunction

  // ---------------------------------------------------------------
  // registers and working signals
  // ---------------------------------------------------------------
  logic [15:0]      baud_div;
  logic             pend_hi;
  logic [7:0]       ctrl1;
  logic [7:0]       ctrl2;
  logic [7:0]       alt_st;
  logic [7:0]       alt_c1;
  logic [7:0]       alt_c2;
  logic [7:0]       stat2;
  logic [7:0]       next_ctrl1;
  logic [7:0]       next_ctrl2;
  logic [7:0]       next_alt_c1;
  logic [7:0]       next_alt_c2;
  logic [7:0]       next_stat2;
  logic [8:0]       tx_char;
  logic             parity_err;
  logic             rxd_m;
  logic             rxd_s;
  logic             txd_m;
  logic             txd_s;
  logic [IDX_W-1:0] idx;
  logic             req;
  logic             wr_go;
  logic             rd_go;
  logic             bank;
  logic [7:0]       rd_byte;
  logic             halted;
  logic             tx_run;
  logic             rx_run;
  logic             loop_act;
  logic             one_wire;
  logic             ir;
  logic [15:0]      active_div;
  logic [15:0]      next_active;
  logic [11:0]      cnt;
  logic [3:0]       phase;
  gen_state_t       gen_state;

  // decode; the bus index is the printed offset
  // offsets 0..7 decode
  assign idx   = adr_i[ADR_LSB +: IDX_W];
  assign req   = cyc_i & stb_i;
  assign wr_go = req & we_i & ack_o & sel_i[0];
  assign rd_go = req & ~we_i & ack_o;
  assign bank  = stat2[S2_BANK];
  assign ir    = alt_c2[A2_IR];

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------

  // two stages; only the second stage feeds any logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      txd_m <= 1'b1;
      txd_s <= 1'b1;
    end else begin
      rxd_m <= rxd_i;
      rxd_s <= rxd_m;
      txd_m <= txd_i;
      txd_s <= txd_m;
    end
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------

  // ack one cycle after the request, dropped the cycle after
  // single access timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  // read mux; bank select swaps the first three words
  // bank 0 view
  always_comb begin
    rd_byte = BYTE_RST;
    case (idx)
      IDX_BAUD_HI: begin
        rd_byte = bank ? (alt_st & ALT_ST_W1C) | (alt_st & 8'h04)
                       : baud_div[15:8];
      end
      IDX_BAUD_LO: begin
        rd_byte = bank ? alt_c1 : baud_div[7:0];
      end
      IDX_CTRL1: begin
        rd_byte = bank ? alt_c2 : ctrl1;
      end
      IDX_CTRL2:   rd_byte = ctrl2;
      IDX_STAT1: begin
        rd_byte = {line_status_i[7:1], parity_err};
      end
      IDX_STAT2:   rd_byte = {bank, 2'b00, stat2[4:1], raf_i};
      IDX_DATA_HI: rd_byte = {rx_char_i[8], tx_char[8], 6'h00};
      IDX_DATA_LO: rd_byte = rx_char_i[7:0];
      default:     rd_byte = BYTE_RST;
    endcase
  end

  // read data captured as ack rises, upper lanes zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req & ~we_i & ~ack_o) begin
      dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------

  // divisor bytes; high write arms a pending flag until low lands
  // pair the divisor writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_div <= BAUD_RST;
      pend_hi  <= 1'b0;
    end else if (wr_go & ~bank & (idx == IDX_BAUD_HI)) begin
      baud_div[15:8] <= dat_i[7:0];
      pend_hi        <= 1'b1;
    end else if (wr_go & ~bank & (idx == IDX_BAUD_LO)) begin
      baud_div[7:0] <= dat_i[7:0];
      pend_hi       <= 1'b0;
    end
  end

  // next control values; outputs take these to move on the write edge
  // control one in bank 0
  always_comb begin
    next_ctrl1  = ctrl1;
    next_ctrl2  = ctrl2;
    next_alt_c1 = alt_c1;
    next_alt_c2 = alt_c2;
    next_stat2  = stat2;
    if (wr_go & ~bank & (idx == IDX_CTRL1)) begin
      next_ctrl1 = dat_i[7:0];
    end
    if (wr_go & (idx == IDX_CTRL2)) begin
      next_ctrl2 = dat_i[7:0];
    end
    // reserved alternate bits masked off
    if (wr_go & bank & (idx == IDX_ALT_C1)) begin
      next_alt_c1 = dat_i[7:0] & ALT_C1_MASK;
    end
    if (wr_go & bank & (idx == IDX_ALT_C2)) begin
      next_alt_c2 = dat_i[7:0] & ALT_C2_MASK;
    end
    if (wr_go & (idx == IDX_STAT2)) begin
      next_stat2 = (dat_i[7:0] & STAT2_MASK) | (dat_i[7:0] & 8'h80);
    end
  end

  // control registers load their next values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1  <= BYTE_RST;
      ctrl2  <= BYTE_RST;
      alt_c1 <= BYTE_RST;
      alt_c2 <= BYTE_RST;
    end else begin
      ctrl1  <= next_ctrl1;
      ctrl2  <= next_ctrl2;
      alt_c1 <= next_alt_c1;
      alt_c2 <= next_alt_c2;
    end
  end

  // alternate status: sticky events in bits 7, 1, 0, write one to clear, set wins; bit 2 loads berrv_i on event 1
  // alternate status in bank 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_st <= BYTE_RST;
    end else begin
      alt_st[7] <= alt_event_i[2] |
                   (alt_st[7] & ~(wr_go & bank &
                    (idx == IDX_ALT_ST) & dat_i[7]));
      alt_st[1] <= alt_event_i[1] |
                   (alt_st[1] & ~(wr_go & bank &
                    (idx == IDX_ALT_ST) & dat_i[1]));
      alt_st[0] <= alt_event_i[0] |
                   (alt_st[0] & ~(wr_go & bank &
                    (idx == IDX_ALT_ST) & dat_i[0]));
      if (alt_event_i[1]) begin
        alt_st[AS_BERRV] <= berrv_i;
      end
    end
  end

  // status two holds bank select and pin controls
  // bank select resets to 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat2 <= BYTE_RST;
    end else begin
      stat2 <= next_stat2;
    end
  end

  // transmit character; ninth bit from the high data word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_char <= 9'h000;
    end else if (wr_go & (idx == IDX_DATA_HI)) begin
      tx_char[8] <= dat_i[DH_TX8];
    end else if (wr_go & (idx == IDX_DATA_LO)) begin
      tx_char[7:0] <= dat_i[7:0];
    end
  end

  // receive parity check; sticky until status one is read
  // parity checked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parity_err <= 1'b0;
    end else if (rx_char_valid_i & ctrl1[C1_PAR] &
                 ((ctrl1[C1_NINE] ? rx_char_i[8] : rx_char_i[7]) !=
                  parity_of(rx_char_i, ctrl1[C1_NINE], ctrl1[C1_ODD]))) begin
      parity_err <= 1'b1;
    end else if (rd_go & (idx == IDX_STAT1)) begin
      parity_err <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // run control and line routing
  // ---------------------------------------------------------------

  assign halted   = ctrl1[C1_WAIT] & wait_mode_i;
  assign tx_run   = ctrl2[C2_TXEN] & ~halted;
  assign rx_run   = ctrl2[C2_RXEN] & ~halted;
  assign loop_act = ctrl1[C1_LOOP] & tx_run & rx_run;
  assign one_wire = loop_act & ctrl1[C1_RX_SOURCE_SELECT];

  // receiver input select, idle high when receiver is off
  // receive pin cut off in loop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_line_o <= 1'b1;
    end else if (~rx_run) begin
      rx_line_o <= 1'b1;
    end else if (loop_act) begin
      rx_line_o <= ctrl1[C1_RX_SOURCE_SELECT] ? txd_s : tx_serial_i;
    end else begin
      rx_line_o <= rxd_s;
    end
  end

  // transmit pin; released when off or listening in single wire
  // idle high, released when disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o      <= 1'b1;
      txd_oe_n_o <= 1'b1;
    end else begin
      txd_o      <= tx_run ? tx_serial_i : 1'b1;
      txd_oe_n_o <= ~(tx_run & (~one_wire | stat2[S2_TXDIR]));
    end
  end

  // configuration outputs follow the write edge
  // data length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      format_o      <= '0;
      pin_ctrl_o    <= '0;
      ctrl2_o       <= BYTE_RST;
      alt_enables_o <= BYTE_RST;
      alt_modes_o   <= BYTE_RST;
      infrared_on_o <= 1'b0;
      tx_run_o      <= 1'b0;
      rx_run_o      <= 1'b0;
    end else begin
      format_o      <= '{nine_bit:        next_ctrl1[C1_NINE],
                         wake_addr:       next_ctrl1[C1_WAKE],
                         idle_after_stop: next_ctrl1[C1_ILT],
                         parity_on:       next_ctrl1[C1_PAR],
                         parity_odd:      next_ctrl1[C1_ODD]};
      pin_ctrl_o    <= next_stat2[4:1];
      ctrl2_o       <= next_ctrl2;
      alt_enables_o <= next_alt_c1;
      alt_modes_o   <= next_alt_c2;
      infrared_on_o <= next_alt_c2[A2_IR];
      tx_run_o      <= next_ctrl2[C2_TXEN] & ~halted;
      rx_run_o      <= next_ctrl2[C2_RXEN] & ~halted;
    end
  end

  // character out with parity in the msb; strobes for the datapath
  // parity generated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_char_o      <= 9'h000;
      tx_load_o      <= 1'b0;
      data_read_o    <= 1'b0;
      address_mark_o <= 1'b0;
    end else begin
      tx_char_o <= tx_char;
      if (ctrl1[C1_PAR] & ctrl1[C1_NINE]) begin
        tx_char_o[8] <= parity_of(tx_char, 1'b1, ctrl1[C1_ODD]);
      end else if (ctrl1[C1_PAR]) begin
        tx_char_o[7] <= parity_of(tx_char, 1'b0, ctrl1[C1_ODD]);
      end
      tx_load_o      <= wr_go & (idx == IDX_DATA_LO);
      data_read_o    <= rd_go & (idx == IDX_DATA_LO);
      address_mark_o <= rx_char_valid_i & ctrl1[C1_WAKE] &
                        (ctrl1[C1_NINE] ? rx_char_i[8] : rx_char_i[7]);
    end
  end

  // ---------------------------------------------------------------
  // baud generator
  // ---------------------------------------------------------------

  // a half-written divisor keeps the old one in force
  assign next_active = pend_hi ? active_div : baud_div;

  // off until first enable; holds on bad divisor or wait halt
  // idle until first enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_state        <= GEN_OFF;
      active_div       <= BAUD_RST;
      cnt              <= 12'h000;
      rx_sample_tick_o <= 1'b0;
    end else begin
      rx_sample_tick_o <= 1'b0;
      case (gen_state)
        GEN_OFF: begin
          if (ctrl2[C2_TXEN] | ctrl2[C2_RXEN]) begin
            gen_state <= GEN_HOLD;
          end
        end
        GEN_HOLD: begin
          cnt <= 12'h000;
          if (~halted & div_ok(next_active, ir)) begin
            gen_state <= GEN_RUN;
          end
        end
        GEN_RUN: begin
          if (halted | ~div_ok(next_active, ir)) begin
            gen_state <= GEN_HOLD;
            cnt       <= 12'h000;
          end else if (cnt == 12'h000) begin
            active_div       <= next_active;
            cnt              <= sample_period(next_active, ir) - 12'h001;
            rx_sample_tick_o <= 1'b1;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        default: gen_state <= GEN_OFF;
      endcase
    end
  end

  // one bit-rate tick per sixteen sample ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase       <= 4'h0;
      baud_tick_o <= 1'b0;
    end else if (gen_state != GEN_RUN) begin
      phase       <= 4'h0;
      baud_tick_o <= 1'b0;
    end else begin
      baud_tick_o <= rx_sample_tick_o & (phase == PHASE_LAST);
      if (rx_sample_tick_o) begin
        phase <= phase + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence wr_ctrl1_s;
    wr_go && !bank && idx == IDX_CTRL1;
  endsequence

  sequence wr_word_s;
    wr_go && !bank && idx == IDX_BAUD_HI ##1 !wr_go [*1];
  endsequence

  ack_one_cycle_a: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  bank_after_reset_a: assert property (
    $fell(rst_i) |-> !bank)
    else $error("bank select not zero after reset");

  alt_reserved_a: assert property (
    req && !we_i && !ack_o && bank && idx == IDX_ALT_C1
      |=> dat_o[6:2] == 5'h00)
    else $error("reserved alternate bits read nonzero");

  gen_idle_a: assert property (
    gen_state == GEN_OFF |-> !rx_sample_tick_o && !baud_tick_o)
    else $error("baud generator ran before first enable");

  gen_small_div_a: assert property (
    !div_ok(next_active, ir) |=> !rx_sample_tick_o)
    else $error("generator ticked on disabled divisor");

  loop_route_a: assert property (
    loop_act && !ctrl1[C1_RX_SOURCE_SELECT] |=> rx_line_o == $past(tx_serial_i))
    else $error("loop path not routed from transmitter");

  wait_halt_a: assert property (
    ctrl1[C1_WAIT] && wait_mode_i |=> !tx_run_o && !rx_run_o)
    else $error("port kept running in wait mode");

  txd_release_a: assert property (
    !ctrl2[C2_TXEN] |=> txd_oe_n_o && txd_o)
    else $error("transmit pin driven while disabled");

  format_follow_a: assert property (
    wr_ctrl1_s |=> format_o.nine_bit == $past(dat_i[C1_NINE]))
    else $error("format output missed control write");

  mixed_div_a: assert property (
    wr_word_s |-> pend_hi && active_div == $past(active_div))
    else $error("half-written divisor reached the generator");

endmodule

`default_nettype wire

// >>> testbench.sv
// self-checking bench for the serial port configuration block
`default_nettype none
module testbench;
  import serial_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, wmode, raf, txs, far, ack, txd, oe_n, rxl, trun, rrun;
  logic tick, ir, rxd, tline;
  logic [4:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  dat, dato;
  line_format_t fmt;
  logic [7:0]   q, r;
  logic [7:0]   c2o, aen, amd;
  logic [3:0]   pc;
  logic [8:0]   txc;
  logic         tload;
  int           n, i;
  int           n_mismatch = 0;
  int           checks_done = 0;
  int           seed = 32'h9b75;
  serial_port_config_map DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dato), .ack_o(ack), .wait_mode_i(wmode), .rxd_i(rxd),
    .txd_i(tline), .txd_o(txd), .txd_oe_n_o(oe_n), .tx_serial_i(txs),
    .line_status_i(8'h00), .raf_i(raf), .alt_event_i(3'h0), .berrv_i(1'b0),
    .rx_char_i(9'h000), .rx_char_valid_i(1'b0), .rx_line_o(rxl),
    .tx_run_o(trun), .rx_run_o(rrun), .rx_sample_tick_o(tick),
    .baud_tick_o(), .infrared_on_o(ir), .format_o(fmt), .pin_ctrl_o(pc),
    .ctrl2_o(c2o), .alt_enables_o(aen), .alt_modes_o(amd), .tx_char_o(txc),
    .tx_load_o(tload), .data_read_o(), .address_mark_o());
  serial_node far_node (.drv_i(txd), .drv_oe_n_i(oe_n), .far_level_i(far),
    .rxd_o(rxd), .txd_line_o(tline));
  // free-running bus clock, 100 ns period
  always #50 clk_i = ~clk_i;
  // one comparison, counted
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic single wishbone cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [2:0] idx,
                    input logic [7:0] d, output logic [7:0] rd);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      conclude();
    end
    rd = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // expected sample period from divisor and infrared mode
  function automatic logic [15:0] period(input logic [15:0] d, input logic m);
    // bit time d (infrared: twice bits 15..1), sixteen samples per bit
    return m ? ({1'b0, d[15:1]} * 16'd2) / 16'd16 : d / 16'd16;
  endfunction
  // cycles between two sample ticks, bounded so a dead generator shows
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (tick !== 1'b1 && c < 200);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (tick !== 1'b1 && c < 200);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #(20000 * 100);
    n_mismatch++;
    conclude();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {cyc, stb, we, wmode, raf, txs, far} = 7'h00;
    adr = 5'h00;
    sel = 4'hf;
    dat = 32'h00000000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({txd, oe_n}, 2'b11);
    for (i = 0; i < 8; i++) begin
      wb(1'b0, i[2:0], 8'h00, q);
      chk(q, 8'h00);
    end
    raf <= 1'b1;
    wb(1'b1, 3'h5, 8'h61, q);
    wb(1'b0, 3'h5, 8'h00, q);
    chk(q, 8'h01);
    repeat (4) begin
      r = 8'($random(seed));
      wb(1'b1, 3'h2, r, q);
      chk(fmt, {r[4], r[3], r[2], r[1], r[0]});
      wb(1'b0, 3'h2, 8'h00, q);
      chk(q, r);
    end
    sel <= 4'he;
    wb(1'b1, 3'h2, ~r, q);
    sel <= 4'hf;
    wb(1'b0, 3'h2, 8'h00, q);
    chk(q, r);
    wb(1'b1, 3'h2, 8'h00, q);
    // divisor written high byte then low byte
    wb(1'b1, 3'h0, 8'h00, q);
    wb(1'b1, 3'h1, 8'h30, q);
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      n += tick;
    end
    chk(n, 0);
    wb(1'b1, 3'h3, 8'h0c, q);
    chk(c2o, 8'h0c);
    gap(n);
    gap(n);
    chk(n, period(16'h0030, 1'b0));
    wb(1'b1, 3'h5, 8'h9e, q);
    chk(pc, 4'hf);
    wb(1'b0, 3'h0, 8'h00, q);
    chk(q, 8'h00);
    wb(1'b1, 3'h1, 8'hff, q);
    chk(aen, 8'h83);
    wb(1'b0, 3'h1, 8'h00, q);
    chk(q, 8'h83);
    wb(1'b1, 3'h2, 8'h80, q);
    chk(ir, 1'b1);
    chk(amd, 8'h80);
    repeat (3) gap(n);
    chk(n, period(16'h0030, 1'b1));
    wb(1'b1, 3'h2, 8'h00, q);
    wb(1'b1, 3'h5, 8'h00, q);
    wb(1'b0, 3'h1, 8'h00, q);
    chk(q, 8'h30);
    wb(1'b1, 3'h2, 8'h80, q);
    repeat (6) begin
      txs <= 1'($random(seed));
      repeat (2) @(posedge clk_i);
      chk(rxl, txs);
    end
    wb(1'b1, 3'h2, 8'ha0, q);
    for (i = 0; i < 2; i++) begin
      far <= i[0];
      repeat (5) @(posedge clk_i);
      chk(rxl, i[0]);
    end
    wb(1'b1, 3'h2, 8'h40, q);
    wmode <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({trun, rrun}, 2'b00);
    wmode <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({trun, rrun}, 2'b11);
    // odd parity put in bit 7 of an eight-bit character
    wb(1'b1, 3'h2, 8'h03, q);
    r = 8'($random(seed));
    wb(1'b1, 3'h7, r, q);
    chk(tload, 1'b1);
    @(posedge clk_i);
    chk(txc, {1'b0, ~^r[6:0], r[6:0]});
    // short divisor runs with infrared off, stops with infrared on
    wb(1'b1, 3'h1, 8'h10, q);
    gap(n);
    gap(n);
    chk(n, period(16'h0010, 1'b0));
    wb(1'b1, 3'h5, 8'h80, q);
    wb(1'b1, 3'h2, 8'h80, q);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      n += tick;
    end
    chk(n, 0);
    conclude();
  end
endmodule
`default_nettype wire
